// >>> design/ctx_ctl.sv
// extended context entry control decoder with accessed-flag updater
// assumes a classic wishbone master; paging entry word held locally
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////
module ctx_ctl
   import ctx_ctl_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // decision outputs and update busy status
   output logic exec_allow_o,
   output logic fault_o,
   output logic use_ext_memtype_o,
   output logic [15:0] domain_tag_o,
   output logic upd_busy_o
);

   ////////////////////////////////////////////////////////////////////
   logic [31:0] cap_ff;
   logic [31:0] entry_ff;
   logic [31:0] req_ff;
   logic [31:0] mem_ff;
   logic [31:0] wback_ff;
   logic ack_ff;
   logic [31:0] dat_ff;
   logic exec_allow_ff;
   logic fault_ff;
   logic use_emt_ff;
   logic [15:0] tag_ff;
   logic busy_ff;
   logic upd_req_ff;
   upd_state_t state_ff;
   upd_state_t nxt_state;
   logic [31:0] snap_ff;

   caps_t caps;
   entry_t ent;
   req_t req;
   logic [15:0] tag_mask;
   logic xrq_eff;
   logic eaf_eff;
   logic emt_eff;
   logic slx_applies;
   logic xrq_applies;
   logic sxp_applies;
   logic nxt_allow;
   logic nxt_fault;
   logic wr;
   logic [31:0] wmask;

   assign caps = caps_t'(cap_ff[9:0]);
   assign ent = entry_t'(entry_ff[20:0]);
   assign req = req_t'(req_ff[9:0]);
   assign wr = cyc_i && stb_i && we_i && !ack_ff;

   ////////////////////////////////////////////////////////////////////
   // byte lane mask
   always_comb begin
      wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
   end

   // effective enables after reserved handling
   always_comb begin
      xrq_eff = ent.exec_request_enable && caps.exec_request_supported;
      eaf_eff = ent.ext_accessed_flag_enable && caps.ext_accessed_flag_supported;
      emt_eff = ent.ext_memtype_enable && caps.nested_xlate_supported
                && caps.memtype_supported;
      slx_applies = req.nested_xlate_enable && xrq_eff;
      xrq_applies = req.pasid_enable && req.has_pasid;
      sxp_applies = req.pasid_enable && xrq_eff && req.supervisor_request_enable
                    && ent.supervisor_exec_protect;
   end

   // domain tag width mask
   always_comb begin
      tag_mask = '0;
      for (int i = 0; i < TAG_W; i++) begin
         if (i < int'(caps.tag_width)) begin
            tag_mask[i] = 1'b1;
         end
      end
   end

   // execute decision
   always_comb begin
      nxt_allow = req.read_ok;
      nxt_fault = 1'b0;
      if (req.exec_req) begin
         if (slx_applies && ent.second_level_exec_enable && !req.leaf_x) begin
            nxt_allow = 1'b0;
         end
         if (xrq_applies && !xrq_eff) begin
            nxt_allow = 1'b0;
            nxt_fault = 1'b1;
         end
         if (sxp_applies && req.has_pasid && req.supervisor && req.user_chain) begin
            nxt_allow = 1'b0;
            nxt_fault = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // wishbone ack, one cycle after request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= cyc_i && stb_i && !ack_ff;
      end
   end

   // read data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_ff <= '0;
      end else if (cyc_i && stb_i && !we_i && !ack_ff) begin
         if (adr_i == CAP_OFS) begin
            dat_ff <= cap_ff;
         end else if (adr_i == CTRL_OFS) begin
            dat_ff <= {29'h0, fault_ff, exec_allow_ff, busy_ff};
         end else if (adr_i == ENTRY_OFS) begin
            dat_ff <= {11'h0, ent.second_level_exec_enable, xrq_eff, eaf_eff,
                       ent.supervisor_exec_protect, ent.domain_tag & tag_mask, emt_eff};
         end else if (adr_i == REQ_OFS) begin
            dat_ff <= req_ff;
         end else if (adr_i == RES_OFS) begin
            dat_ff <= {15'h0, use_emt_ff, tag_ff};
         end else if (adr_i == MEM_OFS) begin
            dat_ff <= mem_ff;
         end else if (adr_i == WBACK_OFS) begin
            dat_ff <= wback_ff;
         end else begin
            dat_ff <= '0;
         end
      end
   end

   // software registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cap_ff <= {22'h0, TAG_W_RST, 5'h00};
         entry_ff <= ENTRY_RST;
         req_ff <= REQ_RST;
      end else if (wr) begin
         if (adr_i == CAP_OFS) begin
            cap_ff <= ((cap_ff & ~wmask) | (dat_i & wmask)) & 32'h0000_03ff;
         end else if (adr_i == ENTRY_OFS) begin
            entry_ff <= ((entry_ff & ~wmask) | (dat_i & wmask)) & 32'h001f_ffff;
         end else if (adr_i == REQ_OFS) begin
            req_ff <= ((req_ff & ~wmask) | (dat_i & wmask)) & 32'h0000_03ff;
         end
      end
   end

   // accessed-flag update trigger (write ctrl bit 0)
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         upd_req_ff <= 1'b0;
      end else begin
         upd_req_ff <= wr && adr_i == CTRL_OFS && sel_i[0] && dat_i[0] && eaf_eff;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read-modify-write engine on the local paging entry word
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (upd_req_ff) begin
               nxt_state = ST_READ;
            end
         end
         ST_READ: begin
            nxt_state = ST_WRITE;
         end
         ST_WRITE: begin
            nxt_state = ST_IDLE;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         snap_ff <= '0;
      end else if (state_ff == ST_READ) begin
         snap_ff <= mem_ff;
      end
   end

   // software writes are locked out while the update holds the word
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mem_ff <= MEM_RST;
         wback_ff <= '0;
      end else if (state_ff == ST_WRITE) begin
         mem_ff <= snap_ff | 32'h0000_0400;
         wback_ff <= snap_ff | 32'h0000_0400;
      end else if (wr && adr_i == MEM_OFS && state_ff == ST_IDLE && !upd_req_ff) begin
         mem_ff <= (mem_ff & ~wmask) | (dat_i & wmask);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_ff <= 1'b0;
      end else begin
         busy_ff <= nxt_state != ST_IDLE;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // registered decisions
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         exec_allow_ff <= 1'b0;
         fault_ff <= 1'b0;
         use_emt_ff <= 1'b0;
         tag_ff <= '0;
      end else begin
         exec_allow_ff <= nxt_allow;
         fault_ff <= nxt_fault;
         use_emt_ff <= emt_eff && req.nested_xlate_enable && req.has_pasid
                       && req.pasid_enable && req.coherent;
         tag_ff <= ent.domain_tag & tag_mask;
      end
   end

   assign dat_o = dat_ff;
   assign ack_o = ack_ff;
   assign exec_allow_o = exec_allow_ff;
   assign fault_o = fault_ff;
   assign use_ext_memtype_o = use_emt_ff;
   assign domain_tag_o = tag_ff;
   assign upd_busy_o = busy_ff;

endmodule // ctx_ctl

// >>> design/ctx_ctl_pkg.sv
// package for the extended context entry control slice (bits 91..71)
// assumes a single 25 MHz clock and classic wishbone register access
package ctx_ctl_pkg;
   // entry bit positions
   localparam int unsigned SLX_BIT = 91;
   localparam int unsigned XRQ_BIT = 90;
   localparam int unsigned EAF_BIT = 89;
   localparam int unsigned SXP_BIT = 88;
   localparam int unsigned TAG_HI = 87;
   localparam int unsigned TAG_LO = 72;
   localparam int unsigned EMT_BIT = 71;
   localparam int unsigned TAG_W = 16;
   localparam int unsigned LEAF_X_BIT = 2;
   // register byte offsets
   localparam logic [7:0] CAP_OFS = 8'h00;
   localparam logic [7:0] CTRL_OFS = 8'h04;
   localparam logic [7:0] ENTRY_OFS = 8'h08;
   localparam logic [7:0] REQ_OFS = 8'h0c;
   localparam logic [7:0] RES_OFS = 8'h10;
   localparam logic [7:0] MEM_OFS = 8'h14;
   localparam logic [7:0] WBACK_OFS = 8'h18;
   // reset values
   localparam logic [31:0] CAP_RST = 32'h0000_0000;
   localparam logic [31:0] ENTRY_RST = 32'h0000_0000;
   localparam logic [31:0] REQ_RST = 32'h0000_0000;
   localparam logic [31:0] MEM_RST = 32'h0000_0000;
   localparam logic [4:0] TAG_W_RST = 5'h10;

   // capability bits (cap register)
   typedef struct packed {
      logic [4:0] tag_width;
      logic caching_mode;
      logic memtype_supported;
      logic ext_accessed_flag_supported;
      logic exec_request_supported;
      logic nested_xlate_supported;
   } caps_t;

   // entry slice 91..71
   typedef struct packed {
      logic second_level_exec_enable;
      logic exec_request_enable;
      logic ext_accessed_flag_enable;
      logic supervisor_exec_protect;
      logic [15:0] domain_tag;
      logic ext_memtype_enable;
   } entry_t;

   // request descriptor
   typedef struct packed {
      logic nested_xlate_enable;
      logic pasid_enable;
      logic supervisor_request_enable;
      logic has_pasid;
      logic exec_req;
      logic supervisor;
      logic read_ok;
      logic leaf_x;
      logic user_chain;
      logic coherent;
   } req_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_READ,
      ST_WRITE
   } upd_state_t;
endpackage

// >>> verif/ctx_ctl_monitor.sv
// port checker for ctx_ctl
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
module ctx_ctl_monitor (
   // clock, reset and bus
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   // design outputs
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic exec_allow_o,
   input wire logic fault_o,
   input wire logic use_ext_memtype_o,
   input wire logic [15:0] domain_tag_o,
   input wire logic upd_busy_o
);
   logic [2:0] wr_ff;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i) begin
      if (rst_i) wr_ff <= 3'h0;
      else wr_ff <= {wr_ff[1:0], cyc_i & stb_i & we_i};
   end
////////////////////////////////////////////////////////////////////////
   ack_next_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
   ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
   ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("stray ack");
   rdata_hold_a: assert property ($changed(dat_o) |-> $past(cyc_i && !we_i))
      else $error("read data moved");
   tag_hold_a: assert property ($changed(domain_tag_o) |-> |wr_ff) else $error("tag moved");
   fault_hold_a: assert property ($changed(fault_o) |-> |wr_ff) else $error("fault moved");
   allow_hold_a: assert property ($changed(exec_allow_o) |-> |wr_ff) else $error("allow moved");
   emt_hold_a: assert property ($changed(use_ext_memtype_o) |-> |wr_ff) else $error("emt moved");
   fault_excl_a: assert property (fault_o |-> !exec_allow_o) else $error("fault yet allowed");
   busy_start_a: assert property ($rose(upd_busy_o) |-> |wr_ff) else $error("busy uncaused");
   busy_len_a: assert property ($rose(upd_busy_o) |-> ##[1:3] !upd_busy_o)
      else $error("busy too long");
endmodule // ctx_ctl_monitor

// >>> verif/dma_req_model.sv
// request descriptor source standing in for a dma device
// assumes next_i is driven by the bench just after a clock edge
`timescale 1ns/10ps
module dma_req_model
   import ctx_ctl_pkg::*;
(
   // clock and strobe
   input wire logic clk_i,
   input wire logic next_i,
   // descriptor
   output req_t req_o
);
   int seed = 44;
   initial req_o = '0;
   always @(posedge clk_i) begin
      if (next_i) req_o <= req_t'($random(seed));
   end
endmodule // dma_req_model

// >>> verif/tb_top.sv
// self-checking bench for ctx_ctl
// assumes the wishbone map and timing of the design hand-over
`timescale 1ns/10ps
module tb_top
   import ctx_ctl_pkg::*;
;
   logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, exec_allow_o, fault_o, use_ext_memtype_o;
   logic upd_busy_o, nxt;
   logic [7:0] adr_i;
   logic [3:0] sel_i;
   logic [31:0] dat_i, dat_o, q, w;
   logic [15:0] domain_tag_o;
   logic [18:0] x;
   caps_t c;
   entry_t e;
   req_t r;
   int seed = 44;
   int n_mismatch = 0;
   int total_checks = 0;
   int i, n;
   always #20 clk_i = ~clk_i;
   ctx_ctl u_ctx_ctl (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .exec_allow_o(exec_allow_o), .fault_o(fault_o), .use_ext_memtype_o(use_ext_memtype_o),
      .domain_tag_o(domain_tag_o), .upd_busy_o(upd_busy_o));
   dma_req_model u_dma_req_model (.clk_i(clk_i), .next_i(nxt), .req_o(r));
////////////////////////////////////////////////////////////////////////
   task wrap_up;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wb(logic wr, logic [7:0] a, logic [31:0] d, output logic [31:0] rd);
      int k;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= wr;
      adr_i <= a;
      dat_i <= d;
      sel_i <= 4'hf;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack_o !== 1'b1 && k < 20);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (k >= 20) begin
         n_mismatch++;
         wrap_up();
      end
   endtask
   function automatic entry_t eff(caps_t cp, entry_t en);
      entry_t v;
      v = en;
      v.exec_request_enable &= cp.exec_request_supported;
      v.ext_accessed_flag_enable &= cp.ext_accessed_flag_supported;
      v.ext_memtype_enable &= cp.nested_xlate_supported & cp.memtype_supported;
      v.domain_tag &= 16'hffff >> (5'd16 - cp.tag_width);
      return v;
   endfunction
   function automatic logic [18:0] dec(entry_t v, req_t rq);
      logic f, al, m;
      f = rq.pasid_enable & rq.has_pasid & rq.exec_req & (!v.exec_request_enable |
         (v.supervisor_exec_protect & rq.supervisor_request_enable & rq.supervisor &
         rq.user_chain));
      al = rq.read_ok & !f & !(rq.exec_req & v.second_level_exec_enable &
         rq.nested_xlate_enable & v.exec_request_enable & !rq.leaf_x);
      m = v.ext_memtype_enable & rq.nested_xlate_enable & rq.pasid_enable & rq.has_pasid &
         rq.coherent;
      return {m, f, al, v.domain_tag};
   endfunction
////////////////////////////////////////////////////////////////////////
   initial begin
      {clk_i, cyc_i, stb_i, we_i, nxt, adr_i, sel_i, dat_i} = '0;
      rst_i = 1'b1;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, CAP_OFS, 32'h0, q);
      chk("cap", q, {22'h0, TAG_W_RST, 5'h0});
      wb(1'b1, 8'hfc, 32'hffffffff, q);
      wb(1'b0, 8'hfc, 32'h0, q);
      chk("unmapped", q, 32'h0);
      for (i = 0; i < 40; i++) begin
         c = caps_t'($random(seed));
         e = entry_t'($random(seed));
         if (i == 0) c = caps_t'(10'h200);
         if (i == 0) e = '1;
         if (c.tag_width > 16) c.tag_width = 5'h08;
         if (c.caching_mode && e.domain_tag == 16'h0) e.domain_tag = 16'h0001;
         nxt <= 1'b1;
         @(posedge clk_i);
         nxt <= 1'b0;
         @(posedge clk_i);
         wb(1'b1, CAP_OFS, {22'h0, c}, q);
         wb(1'b1, ENTRY_OFS, {11'h0, e}, q);
         wb(1'b1, REQ_OFS, {22'h0, r}, q);
         x = dec(eff(c, e), r);
         wb(1'b0, CTRL_OFS, 32'h0, q);
         chk("ctrl", q[2:1], x[17:16]);
         wb(1'b0, RES_OFS, 32'h0, q);
         chk("res", q[16:0], {x[18], x[15:0]});
         wb(1'b0, ENTRY_OFS, 32'h0, q);
         chk("entry", q[20:0], eff(c, e));
         chk("ports", {use_ext_memtype_o, fault_o, exec_allow_o, domain_tag_o}, x);
      end
      $display("test decode done");
      wb(1'b1, CAP_OFS, 32'h0000_0204, q);
      wb(1'b1, ENTRY_OFS, 32'h0004_0000, q);
      w = $random(seed) & ~32'h400;
      wb(1'b1, MEM_OFS, w, q);
      wb(1'b1, CTRL_OFS, 32'h1, q);
      wb(1'b1, MEM_OFS, 32'h0, q);
      n = 0;
      while (upd_busy_o !== 1'b0 && n < 10) begin
         @(posedge clk_i);
         n++;
      end
      chk("busy", upd_busy_o, 1'b0);
      wb(1'b0, MEM_OFS, 32'h0, q);
      chk("mem", q, w | 32'h400);
      wb(1'b0, WBACK_OFS, 32'h0, q);
      chk("wback", q, w | 32'h400);
      $display("test update done");
      wb(1'b1, CAP_OFS, 32'h0000_0200, q);
      wb(1'b1, MEM_OFS, w, q);
      wb(1'b1, CTRL_OFS, 32'h1, q);
      repeat (4) @(posedge clk_i);
      chk("no busy", upd_busy_o, 1'b0);
      wb(1'b0, MEM_OFS, 32'h0, q);
      chk("mem kept", q, w);
      $display("test no update done");
      wrap_up();
   end
endmodule // tb_top

bind ctx_ctl ctx_ctl_monitor u_ctx_ctl_monitor (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
   .ack_o(ack_o), .exec_allow_o(exec_allow_o), .fault_o(fault_o),
   .use_ext_memtype_o(use_ext_memtype_o), .domain_tag_o(domain_tag_o), .upd_busy_o(upd_busy_o));
